// ---- uvpc_consts.svh ----
// Timing counts and geometry for the EPROM programmer controller
`ifndef UVPC_CONSTS_SVH
`define UVPC_CONSTS_SVH
`define UVPC_CLK_PERIOD_NS 5
`define UVPC_ADDR_W 15
`define UVPC_DATA_W 8
`define UVPC_PULSE_US 100
`define UVPC_PULSE_CYC ((`UVPC_PULSE_US * 1000) / `UVPC_CLK_PERIOD_NS)
`define UVPC_ACC_NS 250
`define UVPC_ACC_CYC ((`UVPC_ACC_NS + `UVPC_CLK_PERIOD_NS - 1) / `UVPC_CLK_PERIOD_NS)
`define UVPC_OE_NS 50
`define UVPC_OE_CYC ((`UVPC_OE_NS + `UVPC_CLK_PERIOD_NS - 1) / `UVPC_CLK_PERIOD_NS)
`define UVPC_DF_NS 30
`define UVPC_DF_CYC ((`UVPC_DF_NS + `UVPC_CLK_PERIOD_NS - 1) / `UVPC_CLK_PERIOD_NS)
`define UVPC_MAX_PULSES 25
`define UVPC_ERASED_BYTE 8'hFF
`endif

// ---- uvpc_pkg.sv ----
// Types for the EPROM programmer controller
package uvpc_pkg;
    typedef enum logic [2:0] {
        UVPC_READ = 3'h0,
        UVPC_PROGRAM = 3'h1,
        UVPC_IDENT = 3'h2
    } uvpc_op_t;

    typedef struct packed {
        uvpc_op_t op;
        logic [14:0] addr;
        logic [7:0] data;
        logic id_byte;
    } uvpc_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic fail;
        logic parity_ok;
    } uvpc_rsp_t;

    typedef enum logic [2:0] {
        UVPC_IDLE = 3'b000,
        UVPC_SETUP = 3'b001,
        UVPC_PULSE = 3'b011,
        UVPC_FLOAT = 3'b010,
        UVPC_ACCESS = 3'b110,
        UVPC_DONE = 3'b111
    } uvpc_state_t;
endpackage

// ---- uvpc_ctrl.sv ----
// Programmer-side controller driving the EPROM pins: read, program, identify
// What this block does
// - Byte to program is driven on all eight data lines together.
// - Program voltage high, gate high, chip select low pulse programs.
// - 100 us pulses, verify each, repeat until match or pulse limit.
// - Supply raised while programming and kept raised through the final verify.
// - Chip select held high inhibits programming of that device.
// - Verify with gate low, chip select high, program voltage applied.
// - Identifier mode drives the id address line to high voltage.
// - In identifier mode other address lines are held low.
// - Data read with chip select and gate both low; program verify reads with chip select high.
`timescale 1ns/1ps
`include "uvpc_consts.svh"
module uvpc_ctrl
    import uvpc_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire uvpc_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output uvpc_rsp_t rsp,
    output logic [14:0] address_lines,
    output logic [7:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic [7:0] data_lines_in,
    output logic chip_select_n,
    output logic output_gate_n,
    output logic prog_voltage_en,
    output logic supply_raise_en,
    output logic id_mode_hv_en
);
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(`UVPC_PULSE_CYC);
    localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'(`UVPC_ACC_CYC);
    localparam logic [CNT_W-1:0] DF_CYC = CNT_W'(`UVPC_DF_CYC);
    localparam logic [5:0] MAX_PULSES = 6'(`UVPC_MAX_PULSES);

    logic [7:0] din_s1_reg, din_s2_reg;
    uvpc_state_t state_reg, state_next;
    uvpc_req_t cur_reg, cur_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [5:0] pulses_reg, pulses_next;
    logic [14:0] addr_reg, addr_next;
    logic [7:0] dout_reg, dout_next;
    logic doe_reg, doe_next, ce_n_reg, ce_n_next, oe_n_reg, oe_n_next;
    logic vpp_reg, vpp_next, vcc_reg, vcc_next, hv_reg, hv_next;
    logic ready_reg, ready_next, rv_reg, rv_next;
    uvpc_rsp_t rsp_reg, rsp_next;
    logic match;

    // Data pins are asynchronous to this clock
    always_ff @(posedge clock)
    begin
        din_s1_reg <= data_lines_in;
        din_s2_reg <= din_s1_reg;
    end

    // Verify passes only when the read byte equals the requested byte
    assign match = (din_s2_reg == cur_reg.data);

    always_comb
    begin
        state_next = state_reg;
        cur_next = cur_reg;
        cnt_next = cnt_reg;
        pulses_next = pulses_reg;
        addr_next = addr_reg;
        dout_next = dout_reg;
        doe_next = doe_reg;
        ce_n_next = ce_n_reg;
        oe_n_next = oe_n_reg;
        vpp_next = vpp_reg;
        vcc_next = vcc_reg;
        hv_next = hv_reg;
        ready_next = 1'b0;
        rv_next = 1'b0;
        rsp_next = rsp_reg;
        case (state_reg)
            UVPC_IDLE:
            begin
                ready_next = 1'b1;
                if (req_valid && ready_reg)
                begin
                    ready_next = 1'b0;
                    cur_next = req;
                    pulses_next = 6'h00;
                    cnt_next = ACC_CYC;
                    state_next = UVPC_SETUP;
                    if (req.op == UVPC_IDENT)
                    begin
                        addr_next = {14'h0000, req.id_byte};
                        hv_next = 1'b1;
                        ce_n_next = 1'b0;
                    end
                    else
                    begin
                        addr_next = req.addr;
                        ce_n_next = (req.op == UVPC_PROGRAM);
                    end
                    if (req.op == UVPC_PROGRAM)
                    begin
                        vpp_next = 1'b1;
                        vcc_next = 1'b1;
                        oe_n_next = 1'b1;
                    end
                end
            end
            UVPC_SETUP:
            begin
                // Read and ident: chip select low long enough before the gate falls; program: chip select high until the pulse
                cnt_next = cnt_reg - 16'h0001;
                if (cnt_reg == 16'h0000)
                begin
                    if (cur_reg.op == UVPC_PROGRAM)
                    begin
                        dout_next = cur_reg.data;
                        doe_next = 1'b1;
                        ce_n_next = 1'b0;
                        // One less: the pulse also spans the cycle at count zero
                        cnt_next = PULSE_CYC - 16'h0001;
                        pulses_next = pulses_reg + 6'h01;
                        state_next = UVPC_PULSE;
                    end
                    else
                    begin
                        oe_n_next = 1'b0;
                        cnt_next = ACC_CYC;
                        state_next = UVPC_ACCESS;
                    end
                end
            end
            UVPC_PULSE:
            begin
                cnt_next = cnt_reg - 16'h0001;
                if (cnt_reg == 16'h0000)
                begin
                    ce_n_next = 1'b1;
                    doe_next = 1'b0;
                    cnt_next = DF_CYC;
                    state_next = UVPC_FLOAT;
                end
            end
            UVPC_FLOAT:
            begin
                // Release the bus before the device drives it
                cnt_next = cnt_reg - 16'h0001;
                if (cnt_reg == 16'h0000)
                begin
                    oe_n_next = 1'b0;
                    cnt_next = ACC_CYC;
                    state_next = UVPC_ACCESS;
                end
            end
            UVPC_ACCESS:
            begin
                cnt_next = cnt_reg - 16'h0001;
                if (cnt_reg == 16'h0000)
                begin
                    oe_n_next = 1'b1;
                    if (cur_reg.op == UVPC_PROGRAM && !match && pulses_reg < MAX_PULSES)
                    begin
                        cnt_next = DF_CYC + ACC_CYC;
                        state_next = UVPC_SETUP;
                    end
                    else
                    begin
                        ce_n_next = 1'b1;
                        vpp_next = 1'b0;
                        vcc_next = 1'b0;
                        hv_next = 1'b0;
                        rsp_next.data = din_s2_reg;
                        rsp_next.fail = (cur_reg.op == UVPC_PROGRAM) && !match;
                        rsp_next.parity_ok = ^din_s2_reg;
                        rv_next = 1'b1;
                        cnt_next = DF_CYC;
                        state_next = UVPC_DONE;
                    end
                end
            end
            UVPC_DONE:
            begin
                cnt_next = cnt_reg - 16'h0001;
                if (cnt_reg == 16'h0000)
                begin
                    ready_next = 1'b1;
                    state_next = UVPC_IDLE;
                end
            end
            default:
            begin
                state_next = UVPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_reg <= UVPC_IDLE;
            cur_reg <= '0;
            cnt_reg <= 16'h0000;
            pulses_reg <= 6'h00;
            addr_reg <= 15'h0000;
            dout_reg <= 8'h00;
            doe_reg <= 1'b0;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            vpp_reg <= 1'b0;
            vcc_reg <= 1'b0;
            hv_reg <= 1'b0;
            ready_reg <= 1'b0;
            rv_reg <= 1'b0;
            rsp_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            cnt_reg <= cnt_next;
            pulses_reg <= pulses_next;
            addr_reg <= addr_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
            ce_n_reg <= ce_n_next;
            oe_n_reg <= oe_n_next;
            vpp_reg <= vpp_next;
            vcc_reg <= vcc_next;
            hv_reg <= hv_next;
            ready_reg <= ready_next;
            rv_reg <= rv_next;
            rsp_reg <= rsp_next;
        end
    end

    assign req_ready = ready_reg;
    assign rsp_valid = rv_reg;
    assign rsp = rsp_reg;
    assign address_lines = addr_reg;
    assign data_lines_out = dout_reg;
    assign data_lines_oe = doe_reg;
    assign chip_select_n = ce_n_reg;
    assign output_gate_n = oe_n_reg;
    assign prog_voltage_en = vpp_reg;
    assign supply_raise_en = vcc_reg;
    assign id_mode_hv_en = hv_reg;

    a_no_contention: assert property (@(posedge clock) disable iff (sys_rst)
        data_lines_oe |-> output_gate_n) else $error("Drive while gate low");
    a_prog_gate_high: assert property (@(posedge clock) disable iff (sys_rst)
        (!chip_select_n && prog_voltage_en) |-> output_gate_n)
        else $error("Program pulse with gate low");
    a_prog_data: assert property (@(posedge clock) disable iff (sys_rst)
        (!chip_select_n && prog_voltage_en) |-> data_lines_oe)
        else $error("Program pulse without data");
    a_verify_cs_high: assert property (@(posedge clock) disable iff (sys_rst)
        (!output_gate_n && prog_voltage_en) |-> chip_select_n)
        else $error("Verify with chip select low");
    a_id_addr_low: assert property (@(posedge clock) disable iff (sys_rst)
        id_mode_hv_en |-> address_lines[14:1] == 14'h0000)
        else $error("Address high in id mode");
    a_pulse_limit: assert property (@(posedge clock) disable iff (sys_rst)
        pulses_reg <= MAX_PULSES) else $error("Too many pulses");
    a_raise_with_vpp: assert property (@(posedge clock) disable iff (sys_rst)
        supply_raise_en == prog_voltage_en) else $error("Supply not raised");
    a_rsp_after_idle: assert property (@(posedge clock) disable iff (sys_rst)
        rsp_valid |-> ##1 (chip_select_n && !prog_voltage_en))
        else $error("Not in standby after answer");
    c_read: cover property (@(posedge clock) rsp_valid && cur_reg.op == UVPC_READ);
    c_prog: cover property (@(posedge clock) rsp_valid && cur_reg.op == UVPC_PROGRAM);
    c_ident: cover property (@(posedge clock) rsp_valid && cur_reg.op == UVPC_IDENT);
    c_repulse: cover property (@(posedge clock) state_reg == UVPC_PULSE && pulses_reg == 6'h02);
endmodule

// ---- uvpc_eprom_model.sv ----
// Behavioural model of the 32K x 8 UV EPROM on the controller's pins
`timescale 1ns/1ps
module uvpc_eprom_model #(
    parameter int ACC_CYC = 50,
    parameter int OE_CYC = 10,
    parameter logic [7:0] MAKER_CODE = 8'h83, // Arbitrary value, odd parity
    parameter logic [7:0] DEVICE_CODE = 8'h2A // Arbitrary value, odd parity
) (
    input wire logic clock,
    input wire logic [14:0] address_lines,
    input wire logic [7:0] data_lines,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic prog_voltage_en,
    input wire logic id_mode_hv_en,
    output logic [7:0] q,
    output logic q_en
);
    logic [7:0] mem [0:32767];
    logic [7:0] noise = 8'h00;
    logic [14:0] addr_seen = 15'h0000;
    int acc_cnt = 0;
    int oe_cnt = 0;
    logic [7:0] value;

    initial
    begin
        for (int i = 0; i < 32768; i++)
            mem[i] = 8'hFF;
    end

    always_comb
    begin
        if (id_mode_hv_en && address_lines[14:1] == 14'h0000)
            value = address_lines[0] ? DEVICE_CODE : MAKER_CODE;
        else if (id_mode_hv_en)
            value = noise; // Stray address bits: no defined code
        else
            value = mem[address_lines];
    end

    always @(posedge clock)
    begin
        noise <= noise + 8'h35;
        addr_seen <= address_lines;
        if (chip_select_n || address_lines != addr_seen)
            acc_cnt <= 0;
        else if (acc_cnt < ACC_CYC)
            acc_cnt <= acc_cnt + 1;
        if (output_gate_n)
            oe_cnt <= 0;
        else if (oe_cnt < OE_CYC)
            oe_cnt <= oe_cnt + 1;
        if (!chip_select_n && output_gate_n && prog_voltage_en)
            mem[address_lines] <= mem[address_lines] & data_lines;
    end

    // Released bus shows a changing pattern, not a held last byte
    always_comb
    begin
        q_en = 1'b0;
        q = noise;
        if (!chip_select_n && !output_gate_n && acc_cnt >= ACC_CYC && oe_cnt >= OE_CYC)
        begin
            q_en = 1'b1;
            q = value;
        end
        else if (chip_select_n && !output_gate_n && prog_voltage_en && oe_cnt >= OE_CYC)
        begin
            q_en = 1'b1;
            q = mem[address_lines];
        end
    end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the EPROM programmer controller
`timescale 1ns/1ps
`include "uvpc_consts.svh"
module tb_top
    import uvpc_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    uvpc_req_t req = '0;
    logic req_ready, rsp_valid, data_lines_oe, chip_select_n, output_gate_n;
    logic prog_voltage_en, supply_raise_en, id_mode_hv_en, eprom_q_en;
    uvpc_rsp_t rsp, got;
    logic [14:0] address_lines;
    logic [7:0] data_lines_out, eprom_q, dq;
    int n_errors = 0;
    int compares = 0;
    int pulse_len = 0;

    always #2.5 clock = ~clock;
    assign dq = data_lines_oe ? data_lines_out : eprom_q;

    uvpc_ctrl dut (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
        .address_lines(address_lines), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe), .data_lines_in(dq), .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n), .prog_voltage_en(prog_voltage_en),
        .supply_raise_en(supply_raise_en), .id_mode_hv_en(id_mode_hv_en));

    uvpc_eprom_model #(.ACC_CYC(`UVPC_ACC_CYC), .OE_CYC(`UVPC_OE_CYC)) eprom (
        .clock(clock), .address_lines(address_lines), .data_lines(dq),
        .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
        .prog_voltage_en(prog_voltage_en), .id_mode_hv_en(id_mode_hv_en),
        .q(eprom_q), .q_en(eprom_q_en));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One request, held until taken; answer left in got
    task automatic op_req(input uvpc_op_t op, input logic [14:0] a, input logic [7:0] d,
        input logic b);
        int n;
        @(posedge clock);
        req_valid <= 1'b1;
        req <= {op, a, d, b};
        for (n = 0; n < 100 && req_ready !== 1'b1; n++)
            @(negedge clock);
        if (n >= 100)
        begin
            n_errors++;
            conclude();
        end
        else
        begin
            @(posedge clock);
            req_valid <= 1'b0;
            for (n = 0; n < 30000 && rsp_valid !== 1'b1; n++)
                @(negedge clock);
            if (n >= 30000)
            begin
                n_errors++;
                conclude();
            end
            else
                got = rsp;
        end
    endtask

    // Bus watch: no contention, quiet address in ident, pulse shape
    always @(negedge clock)
    begin
        if (eprom_q_en && data_lines_oe)
            chk(32'h1, 32'h0);
        if (id_mode_hv_en)
            chk(32'(address_lines[14:1]), 32'h0);
        if (!chip_select_n && prog_voltage_en && output_gate_n)
        begin
            pulse_len++;
            if (pulse_len == 1)
                chk(32'(supply_raise_en), 32'h1);
        end
        else if (pulse_len != 0)
        begin
            chk(pulse_len, `UVPC_PULSE_CYC);
            pulse_len = 0;
        end
    end

    task automatic t_read_erased();
        op_req(UVPC_READ, 15'h7FFF, 8'h00, 1'b0);
        chk(32'(got.data), 32'hFF);
    endtask

    // Top address to zero, then its neighbour must stay erased
    task automatic t_program_top();
        op_req(UVPC_PROGRAM, 15'h7FFF, 8'h00, 1'b0);
        chk(32'(got.fail), 32'h0);
        chk(32'(got.data), 32'h00);
        op_req(UVPC_READ, 15'h7FFF, 8'hFF, 1'b0);
        chk(32'(got.data), 32'h00);
        op_req(UVPC_READ, 15'h7FFE, 8'h00, 1'b0);
        chk(32'(got.data), 32'hFF);
    endtask

    task automatic t_program_mixed();
        op_req(UVPC_PROGRAM, 15'h0000, 8'hA5, 1'b0);
        chk(32'(got.fail), 32'h0);
        op_req(UVPC_READ, 15'h0000, 8'h00, 1'b0);
        chk(32'(got.data), 32'hA5);
    endtask

    task automatic t_ident();
        op_req(UVPC_IDENT, 15'h0000, 8'h00, 1'b0);
        chk(32'(got.data), 32'h83);
        chk(32'(got.parity_ok), 32'h1);
        op_req(UVPC_IDENT, 15'h0000, 8'h00, 1'b1);
        chk(32'(got.data), 32'h2A);
        chk(32'(got.parity_ok), 32'h1);
    endtask

    task automatic t_standby();
        repeat (20) @(posedge clock);
        // Look away from the launching edge
        @(negedge clock);
        chk(32'(chip_select_n), 32'h1);
        chk(32'(data_lines_oe), 32'h0);
        chk(32'(prog_voltage_en), 32'h0);
        chk(32'(output_gate_n), 32'h1);
        chk(32'(eprom_q_en), 32'h0);
    endtask

    initial
    begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        t_standby();
        t_read_erased();
        t_program_top();
        t_program_mixed();
        t_ident();
        t_standby();
        conclude();
    end
endmodule
